/* File: pdb_consts.vh */
// constants for the dead-band and restart control block
`ifndef PDB_CONSTS_VH
`define PDB_CONSTS_VH

// ==========================================================
// register byte offsets on the apb bus
`define PDB_OFS_PWM_CTRL      8'h00
`define PDB_OFS_SHDN_CTRL     8'h04
`define PDB_OFS_IRQ_STATUS    8'h08
`define PDB_OFS_IRQ_MASK      8'h0C

// ==========================================================
// reset values
`define PDB_RST_PWM_CTRL      8'h00
`define PDB_RST_SHDN_CTRL     8'h00
`define PDB_RST_IRQ_STATUS    2'h0
`define PDB_RST_IRQ_MASK      2'h0

// ==========================================================
// enhanced_pwm_control fields
`define PDB_BIT_RESTART_EN    7
`define PDB_DB_MSB            6
`define PDB_DB_W              7

// ==========================================================
// auto_shutdown_control fields
`define PDB_BIT_SHDN_FLAG     7
`define PDB_SRC_MSB           6
`define PDB_SRC_LSB           4
`define PDB_PRI_ST_MSB        3
`define PDB_PRI_ST_LSB        2
`define PDB_CMP_ST_MSB        1
`define PDB_CMP_ST_LSB        0

// ==========================================================
// interrupt status / mask layout
`define PDB_IRQ_W             2
`define PDB_IRQ_SHDN          0
`define PDB_IRQ_RESUME        1

// ==========================================================
// timing: oscillator periods per instruction cycle
`define PDB_TOSC_PER_TCY      4
`define PDB_PRE_W             2

`endif

/* File: pdb_deadband.v */
// turn-on delay counter for one bridge output
`timescale 1ns/1ns
`include "pdb_consts.vh"
`default_nettype none

module pdb_deadband (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   target,  // wanted active level
    input  wire                   tick,    // one per instruction cycle
    input  wire [`PDB_DB_W-1:0]   count,   // delay in instruction cycles
    output reg                    active   // delayed active level
);

    reg                 prev_q;  // target one cycle ago
    reg                 busy_q;  // delay running
    reg [`PDB_DB_W-1:0] cnt_q;   // remaining instruction cycles

    wire rise = target & ~prev_q;

    // ==========================================================
    // delay only inactive-to-active; drop at once on turn-off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q  <= {`PDB_DB_W{1'b0}};
            active <= 1'b0;
        end else begin
            prev_q <= target;
            if (!target) begin
                // turn-off is never delayed; a pending delay dies here,
                // so a count longer than the pulse keeps it inactive
                busy_q <= 1'b0;
                active <= 1'b0;
            end else if (rise) begin
                cnt_q <= count;
                if (count == {`PDB_DB_W{1'b0}}) begin
                    active <= 1'b1;
                    busy_q <= 1'b0;
                end else begin
                    busy_q <= 1'b1;
                end
            end else if (busy_q && tick) begin
                // counting instruction cycles, not clock edges
                if (cnt_q == {{(`PDB_DB_W-1){1'b0}}, 1'b1}) begin
                    busy_q <= 1'b0;
                    active <= 1'b1;
                end
                cnt_q <= cnt_q - {{(`PDB_DB_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // pdb_deadband
`default_nettype wire

/* File: pdb_gate_model.sv */
// behavioural gate drivers on the far side of the bridge pins
`timescale 1ns/1ns
`default_nettype none

module pdb_gate_model (
    input  wire logic        clk,
    input  wire logic        hi_drv,
    input  wire logic        hi_oe,
    input  wire logic        lo_drv,
    input  wire logic        lo_oe,
    output var  logic [15:0] overlap_cnt
);
    // ==========================================================
    // released pin falls to its pull-down: switch stays off
    wire hi_gate = hi_oe ? hi_drv : 1'b0;
    wire lo_gate = lo_oe ? lo_drv : 1'b0;

    // ==========================================================
    // both switches on together is shoot-through, count it
    initial overlap_cnt = 16'h0;
    always @(posedge clk) begin
        if (hi_gate === 1'b1 && lo_gate === 1'b1) begin
            overlap_cnt <= overlap_cnt + 16'h1;
        end
    end
endmodule // pdb_gate_model

`default_nettype wire

/* File: pdb_sync.v */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ns
`default_nettype none

module pdb_sync (
    input  wire clk,
    input  wire rst_n,
    input  wire din,
    output reg  dout
);

    reg s1_q; // first stage, read only by s2_q
    reg s2_q; // second stage
    reg s3_q; // third stage

    // ==========================================================
    // shift chain; output moves once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a one-cycle glitch never reaches the output
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end

endmodule // pdb_sync
`default_nettype wire

/* File: pdb_top.v */
// half-bridge dead-band and auto-restart control with apb registers
`timescale 1ns/1ns
`include "pdb_consts.vh"
`default_nettype none

module pdb_top (
    input  wire        clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // from the period and duty generator, same clock
    input  wire        pwm_raw,
    input  wire        period_start,
    // external shutdown condition pin, active high
    input  wire        shutdown_in,
    // bridge outputs
    output reg         pwm_out_primary,
    output reg         pwm_out_primary_oe,
    output reg         pwm_out_complement,
    output reg         pwm_out_complement_oe,
    output reg         irq
);

    // ==========================================================
    // reset release
    reg rst_s1_q;  // first reset stage
    reg rst_s2_q;  // released reset used by the whole block

    // release is synchronous, assertion stays asynchronous
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // every other process takes its reset from this released copy
    wire rst_i_n = rst_s2_q;

    // ==========================================================
    // registers
    reg [7:0]            pwm_ctrl_q;   // enhanced_pwm_control
    reg [6:0]            shdn_cfg_q;   // auto_shutdown_control low bits
    reg                  shdn_flag_q;  // shutdown_event_flag
    // status and mask share one layout: shutdown bit 0, resume bit 1
    reg [`PDB_IRQ_W-1:0] irq_stat_q;   // sticky events
    reg [`PDB_IRQ_W-1:0] irq_mask_q;   // interrupt enables
    reg [`PDB_IRQ_W-1:0] rd_clr_q;     // status bits handed to a read
    reg                  rd_stat_q;    // pending read of status

    wire                 auto_restart_enable = pwm_ctrl_q[`PDB_BIT_RESTART_EN];
    wire [`PDB_DB_W-1:0] deadband_count = pwm_ctrl_q[`PDB_DB_MSB:0];

    // ==========================================================
    // apb decode
    wire apb_acc   = psel & penable;
    wire apb_cap   = apb_acc & ~pready;   // first access cycle
    wire apb_done  = apb_acc & pready;    // completing edge
    wire wr_done   = apb_done & pwrite & ~pslverr;
    wire ofs_ctrl  = (paddr == `PDB_OFS_PWM_CTRL);
    wire ofs_shdn  = (paddr == `PDB_OFS_SHDN_CTRL);
    wire ofs_stat  = (paddr == `PDB_OFS_IRQ_STATUS);
    wire ofs_mask  = (paddr == `PDB_OFS_IRQ_MASK);
    wire mapped    = ofs_ctrl | ofs_shdn | ofs_stat | ofs_mask;

    // read mux, upper bits read as zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `PDB_OFS_PWM_CTRL:   rd_mux = {24'h00_0000, pwm_ctrl_q};
            `PDB_OFS_SHDN_CTRL:  rd_mux = {24'h00_0000, shdn_flag_q,
                                           shdn_cfg_q};
            `PDB_OFS_IRQ_STATUS: rd_mux = {30'h0000_0000, irq_stat_q};
            `PDB_OFS_IRQ_MASK:   rd_mux = {30'h0000_0000, irq_mask_q};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // apb handshake: one wait state, data captured before ready
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            rd_clr_q  <= {`PDB_IRQ_W{1'b0}};
            rd_stat_q <= 1'b0;
        end else if (apb_cap) begin
            pready    <= 1'b1;
            pslverr   <= ~mapped;               // unmapped answers error
            prdata    <= pwrite ? 32'h0000_0000 : rd_mux;
            rd_clr_q  <= irq_stat_q;
            rd_stat_q <= ~pwrite & ofs_stat;
        end else begin
            // ready and error last exactly one cycle
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            rd_stat_q <= 1'b0;
        end
    end

    // ==========================================================
    // plain control registers; the flag keeps its own process
    localparam [7:0] SHDN_RST = `PDB_RST_SHDN_CTRL; // flag over config
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pwm_ctrl_q <= `PDB_RST_PWM_CTRL;
            shdn_cfg_q <= SHDN_RST[6:0];
            irq_mask_q <= `PDB_RST_IRQ_MASK;
        end else if (wr_done) begin
            if (ofs_ctrl) begin
                pwm_ctrl_q <= pwdata[7:0];
            end
            if (ofs_shdn) begin
                shdn_cfg_q <= pwdata[6:0];
            end
            if (ofs_mask) begin
                irq_mask_q <= pwdata[`PDB_IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // shutdown condition
    wire shdn_pin_s;  // filtered pin level

    pdb_sync u_sync (
        .clk   (clk),
        .rst_n (rst_i_n),
        .din   (shutdown_in),
        .dout  (shdn_pin_s)
    );

    // any source selection other than all-zero arms the pin; the
    // individual source kinds live outside this block
    // the shutdown-state bits below the source field never arm it
    wire src_armed = |shdn_cfg_q[`PDB_SRC_MSB:`PDB_SRC_LSB];
    wire shdn_cond = src_armed & shdn_pin_s;  // level, not edge
    wire flag_wr   = wr_done & ofs_shdn;
    wire flag_wval = pwdata[`PDB_BIT_SHDN_FLAG];

    // ==========================================================
    // shutdown_event_flag: set by condition or firmware
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            shdn_flag_q <= SHDN_RST[`PDB_BIT_SHDN_FLAG];
        end else if (shdn_cond) begin
            // condition wins over any clear while it persists
            shdn_flag_q <= 1'b1;
        end else if (flag_wr) begin
            // firmware may force or clear the flag
            shdn_flag_q <= flag_wval;
        end else if (auto_restart_enable) begin
            // condition gone: hardware clears by itself
            shdn_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // run state: resume waits for the next period start
    reg run_q;   // bridge outputs follow the pwm
    reg run_d;

    always @* begin
        run_d = run_q;
        if (shdn_flag_q) begin
            run_d = 1'b0;
        end else if (period_start) begin
            run_d = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // ==========================================================
    // instruction-cycle tick: one clock in four
    reg [`PDB_PRE_W-1:0] pre_q;  // oscillator period counter
    reg                  tick_q; // one-cycle instruction tick

    // phase runs free from reset, so a delay may start anywhere in it
    // and a turn-on may come up to three clocks before its nominal time
    localparam integer          PRE_LAST_I = `PDB_TOSC_PER_TCY - 1;
    localparam [`PDB_PRE_W-1:0] PRE_LAST   = PRE_LAST_I[`PDB_PRE_W-1:0];

    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pre_q  <= {`PDB_PRE_W{1'b0}};
            tick_q <= 1'b0;
        end else begin
            tick_q <= (pre_q == PRE_LAST);
            if (pre_q == PRE_LAST) begin
                pre_q <= {`PDB_PRE_W{1'b0}};
            end else begin
                pre_q <= pre_q + {{(`PDB_PRE_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ==========================================================
    // per-output dead-band stages
    wire [1:0] tgt;    // wanted active levels, primary first
    wire [1:0] dly;    // delayed active levels

    // primary follows the pwm, second its complement
    assign tgt[0] = run_q & pwm_raw;
    assign tgt[1] = run_q & ~pwm_raw;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_db
            pdb_deadband u_db (
                .clk    (clk),
                .rst_n  (rst_i_n),
                .target (tgt[gi]),
                .tick   (tick_q),
                .count  (deadband_count),
                .active (dly[gi])
            );
        end
    endgenerate

    // ==========================================================
    // output stage with shutdown states
    wire [1:0] pri_st = shdn_cfg_q[`PDB_PRI_ST_MSB:`PDB_PRI_ST_LSB];
    wire [1:0] cmp_st = shdn_cfg_q[`PDB_CMP_ST_MSB:`PDB_CMP_ST_LSB];

    // in shutdown the pins take the programmed state at once;
    // drivers are released in reset, polarity is active high
    // a floated pin is left to the board's pull resistor
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pwm_out_primary       <= 1'b0;
            pwm_out_primary_oe    <= 1'b0;
            pwm_out_complement    <= 1'b0;
            pwm_out_complement_oe <= 1'b0;
        end else if (shdn_flag_q || shdn_cond) begin
            pwm_out_primary       <= pri_st[0];
            pwm_out_primary_oe    <= ~pri_st[1];  // 1x floats the pin
            pwm_out_complement    <= cmp_st[0];
            pwm_out_complement_oe <= ~cmp_st[1];
        end else begin
            pwm_out_primary       <= dly[0];
            pwm_out_primary_oe    <= 1'b1;
            pwm_out_complement    <= dly[1];
            pwm_out_complement_oe <= 1'b1;
        end
    end

    // ==========================================================
    // interrupts: shutdown entry and pwm resume events
    reg flag_prev_q;  // flag one cycle ago
    reg run_prev_q;   // run one cycle ago

    wire [`PDB_IRQ_W-1:0] ev_set = {run_q & ~run_prev_q,
                                    shdn_flag_q & ~flag_prev_q};
    wire [`PDB_IRQ_W-1:0] ev_clr = rd_stat_q & apb_done ?
                                   rd_clr_q : {`PDB_IRQ_W{1'b0}};

    // read clears only what it reported; new events win
    // irq takes the next status value, so it moves with the bits
    always @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            flag_prev_q <= 1'b0;
            run_prev_q  <= 1'b0;
            irq_stat_q  <= `PDB_RST_IRQ_STATUS;
            irq         <= 1'b0;
        end else begin
            flag_prev_q <= shdn_flag_q;
            run_prev_q  <= run_q;
            irq_stat_q  <= (irq_stat_q & ~ev_clr) | ev_set;
            irq         <= |(((irq_stat_q & ~ev_clr) | ev_set) &
                             irq_mask_q);
        end
    end

endmodule // pdb_top
`default_nettype wire

/* File: pdb_top_sva.sv */
// port-level assertions for the dead-band and restart block
`timescale 1ns/1ns
`default_nettype none

module pdb_top_sva (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        pwm_raw,
    input  wire logic        pwm_out_primary,
    input  wire logic        pwm_out_complement,
    input  wire logic        pwm_out_complement_oe
);
    // ==========================================================
    // single clock domain, async reset
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // bus answer timing
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    ready_latency_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("ready late after first access cycle");
    ready_cause_a: assert property (
        $rose(pready) |-> $past(psel && penable))
        else $error("ready without an access phase");
    err_strobe_a: assert property (pslverr |-> pready)
        else $error("error flag outside ready cycle");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("unused read bits not zero");

    // ==========================================================
    // bridge outputs follow the raw pwm when running; shutdown
    // state of 1x releases the complement, which excuses the output here
    primary_off_a: assert property (!pwm_raw [*3] |=>
        !pwm_out_primary || !pwm_out_complement_oe)
        else $error("primary active while pwm low");
    complement_off_a: assert property (pwm_raw [*3] |=>
        !pwm_out_complement || !pwm_out_complement_oe)
        else $error("complement active while pwm high");
endmodule // pdb_top_sva

bind pdb_top pdb_top_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_raw(pwm_raw),
    .pwm_out_primary(pwm_out_primary),
    .pwm_out_complement(pwm_out_complement),
    .pwm_out_complement_oe(pwm_out_complement_oe));

`default_nettype wire

/* File: pdb_top_tb.sv */
// self-checking bench for the dead-band and restart block
`timescale 1ns/1ns
`default_nettype none

module pdb_top_tb;
    // ==========================================================
    // stimulus, observed outputs, counters
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pwm_raw;
    logic        period_start;
    logic        shutdown_in;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq;
    wire         pwm_out_primary, pwm_out_primary_oe;
    wire         pwm_out_complement, pwm_out_complement_oe;
    wire  [15:0] overlap;
    logic [31:0] rd, v;
    logic        er;
    int          errors, n_tests, c;
    int          cnt[5] = '{0, 1, 2, 127, 0};

    pdb_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_raw(pwm_raw),
        .period_start(period_start), .shutdown_in(shutdown_in),
        .pwm_out_primary(pwm_out_primary),
        .pwm_out_primary_oe(pwm_out_primary_oe),
        .pwm_out_complement(pwm_out_complement),
        .pwm_out_complement_oe(pwm_out_complement_oe), .irq(irq));
    pdb_gate_model gates (.clk(clk), .hi_drv(pwm_out_primary),
        .hi_oe(pwm_out_primary_oe), .lo_drv(pwm_out_complement),
        .lo_oe(pwm_out_complement_oe), .overlap_cnt(overlap));

    // ==========================================================
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // apb transfer: setup, access held until ready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) errors++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic pstart();
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
    endtask

    // pin summary: irq, primary, its enable, gated complement, enable
    function automatic logic [31:0] st();
        return {27'h0, irq, pwm_out_primary, pwm_out_primary_oe,
                pwm_out_complement & pwm_out_complement_oe,
                pwm_out_complement_oe};
    endfunction

    // model range of a turn-on delay for count k, in sampled cycles
    function automatic int clip(int t, int k);
        int lb;
        int ub;
        lb = (k == 0) ? 1 : 4 * k - 2;
        ub = 4 * k + 4;
        return (t < lb) ? lb : ((t > ub) ? ub : t);
    endfunction

    // one pwm pulse of hi cycles, edge times measured against count k
    task automatic db_run(input int k, input int hi);
        int t, tp, tc, tf;
        tp = -1;
        tc = -1;
        tf = -1;
        apb(1'b1, 8'h00, k);
        cyc(4 * k + 12);
        pwm_raw <= 1'b1;
        for (t = 1; t <= hi + 4 * k + 12; t++) begin
            @(posedge clk);
            if (t == hi) pwm_raw <= 1'b0;
            if (tf < 0 && pwm_out_complement === 1'b0) tf = t;
            if (tp < 0 && pwm_out_primary === 1'b1) tp = t;
            if (t > hi && tc < 0 && pwm_out_complement === 1'b1) tc = t - hi;
        end
        chk("turn-off", (tf >= 1 && tf <= 3) ? tf : 3, tf);
        chk("complement turn-on", clip(tc, k), tc);
        if (hi > 4 * k + 4) chk("primary turn-on", clip(tp, k), tp);
        else chk("primary held off", -1, tp);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // watchdog: tests need under 4000 cycles
    initial begin
        #80000;
        errors++;
        complete_run();
    end

    // ==========================================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {pwm_raw, period_start, shutdown_in, errors, n_tests} = '0;
        void'($urandom(32'h18b2f952));
        cyc(20);
        rst_n <= 1'b1;
        cyc(3);
        rchk(8'h00, 32'h0, "control reset");
        rchk(8'h04, 32'h0, "shutdown reset");
        rchk(8'h08, 32'h0, "status reset");
        rchk(8'h0C, 32'h0, "mask reset");
        v = $urandom;
        apb(1'b1, 8'h00, v);
        rchk(8'h00, {24'h0, v[7:0]}, "control readback");
        apb(1'b1, 8'h10, v);
        chk("unmapped error", 32'h1, {31'h0, er});
        rchk(8'h10, 32'h0, "unmapped read");
        $display("test registers done");
        // start the pwm, then sweep counts, one random, one too long
        pstart();
        cnt[4] = 3 + $urandom % 58;
        foreach (cnt[i]) db_run(cnt[i], 4 * cnt[i] + 10);
        c = 8 + $urandom % 13;
        db_run(c, 4 * c - 6);
        $display("test dead band done");
        // shutdown, restart by firmware
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h04, 32'h16);
        shutdown_in <= 1'b1;
        cyc(12);
        chk("shutdown pins", 32'h1C, st());
        rchk(8'h08, 32'h1, "status shutdown");
        cyc(2);
        chk("irq after read", 32'h0C, st());
        apb(1'b1, 8'h04, 32'h16);
        rchk(8'h04, 32'h96, "flag write refused");
        shutdown_in <= 1'b0;
        cyc(12);
        rchk(8'h04, 32'h96, "flag held");
        apb(1'b1, 8'h04, 32'h16);
        cyc(8);
        chk("wait for period", 32'h05, st());
        pstart();
        cyc(6);
        chk("resumed pins", 32'h17, st());
        rchk(8'h08, 32'h2, "status resume");
        $display("test firmware restart done");
        // shutdown, automatic restart, shutdown event masked
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h04, 32'h19);
        apb(1'b1, 8'h00, 32'h80);
        shutdown_in <= 1'b1;
        cyc(12);
        chk("masked shutdown", 32'h03, st());
        shutdown_in <= 1'b0;
        cyc(12);
        rchk(8'h04, 32'h19, "flag auto clear");
        pstart();
        cyc(6);
        chk("auto resumed pins", 32'h17, st());
        rchk(8'h08, 32'h3, "status both");
        chk("bridge overlap", 32'h0, {16'h0, overlap});
        $display("test auto restart done");
        // reset in mid-run: pins released, registers back to zero
        rst_n <= 1'b0;
        cyc(2);
        chk("pins in reset", 32'h0, st());
        rst_n <= 1'b1;
        cyc(3);
        rchk(8'h00, 32'h0, "control after reset");
        rchk(8'h04, 32'h0, "shutdown after reset");
        $display("test mid-run reset done");
        complete_run();
    end
endmodule // pdb_top_tb

`default_nettype wire
